// [src/psm_consts.svh]
// constants of the pipelined signed multiplier: widths, register offsets,
// field positions and reset values; included by the package and psm_mult
`ifndef PSM_CONSTS_SVH
`define PSM_CONSTS_SVH

// operand and product widths
`define PSM_OPERAND_W      18
`define PSM_PRODUCT_W      36
// product bits above the low data word
`define PSM_PRODUCT_HI_W   4

// apb address width and register byte offsets
`define PSM_APB_AW         12
`define PSM_CTRL_OFS       12'h000
`define PSM_STATUS_OFS     12'h004
`define PSM_PROD_LO_OFS    12'h008
`define PSM_PROD_HI_OFS    12'h00c
`define PSM_CHAIN_OFS      12'h010

// control register fields
`define PSM_CTRL_RAM_WIDE_BIT  0
`define PSM_CTRL_RESET         1'h0

// status register fields
`define PSM_STAT_RAM_WIDE_BIT  0
`define PSM_STAT_FIRST_REG_BIT 1
`define PSM_STAT_SECOND_REG_BIT 2
`define PSM_STAT_PROD_REG_BIT  3
`define PSM_STAT_CHAINED_BIT   4

// reset values of the datapath registers and the bus answer
`define PSM_OPERAND_RESET  18'h00000
`define PSM_PRODUCT_RESET  36'h000000000
`define PSM_RDATA_RESET    32'h00000000

`endif

// [src/psm_mult.sv]
// 18 by 18 signed multiplier slice with optional operand and product
// registers, a chained second-operand path and a small apb status port.
// assumes fabric logic on ref_clk_in drives the operand and control pins
// and consumes the product; the neighbouring ram reports its wide mode
// through the control register.
//
// Behaviour
// - first operand 18-bit signed, may pass combinationally
// - direct source takes second operand pin
// - chained source takes neighbour's chained operand
// - output 36-bit signed product of operands
// - no registers means product is combinational
// - product register updates on edge, enable, clear
// - both operand registers give edge-only product changes
// - one operand register gives mixed timing
// - chain output carries applied second operand
// - second operand register drives chain output
// - first register loads when enabled, not cleared
// - first clear zeroes register, beats enable
// - second register loads when enabled, not cleared
// - second clear zeroes register, beats enable
// - product register captures when enabled, not cleared
// - product clear zeroes register, beats enable
// - clock, enables, clears have polarity options
// - ram wide mode makes multiplier unavailable
`timescale 1ns/1ns
`default_nettype none

`include "psm_consts.svh"

module psm_mult
#(
   parameter bit               FIRST_REG_PRESENT  = 1'b1,
   parameter bit               SECOND_REG_PRESENT = 1'b1,
   parameter bit               PRODUCT_REG_PRESENT = 1'b1,
   parameter psm_pkg::psm_src_t SOURCE_SEL        = psm_pkg::PSM_SRC_DIRECT,
   parameter bit               INV_CLK            = 1'b0,
   parameter bit               INV_FIRST_ENABLE   = 1'b0,
   parameter bit               INV_FIRST_CLEAR    = 1'b0,
   parameter bit               INV_SECOND_ENABLE  = 1'b0,
   parameter bit               INV_SECOND_CLEAR   = 1'b0,
   parameter bit               INV_PRODUCT_ENABLE = 1'b0,
   parameter bit               INV_PRODUCT_CLEAR  = 1'b0
)
(
   input  wire logic                 ref_clk_in,                 // 50 MHz clock
   input  wire logic                 rst_in,                     // async reset
   input  wire psm_pkg::psm_operand_t first_operand_in,          // operand a
   input  wire psm_pkg::psm_operand_t second_operand_in,         // direct b
   input  wire psm_pkg::psm_operand_t chain_operand_in,          // chained b
   input  wire logic                 first_operand_enable_in,    // a enable
   input  wire logic                 first_operand_sync_clear_in, // a clear
   input  wire logic                 second_operand_enable_in,   // b enable
   input  wire logic                 second_operand_sync_clear_in, // b clear
   input  wire logic                 product_enable_in,          // p enable
   input  wire logic                 product_sync_clear_in,      // p clear
   output psm_pkg::psm_product_t     product_out,                // product
   output psm_pkg::psm_operand_t     chain_operand_out,          // applied b
   input  wire logic                 psel_in,                    // apb select
   input  wire logic                 penable_in,                 // apb enable
   input  wire logic                 pwrite_in,                  // apb write
   input  wire psm_pkg::psm_addr_t   paddr_in,                   // apb address
   input  wire psm_pkg::psm_data_t   pwdata_in,                  // apb wdata
   output logic                      pready_out,                 // apb ready
   output psm_pkg::psm_data_t        prdata_out,                 // apb rdata
   output logic                      pslverr_out                 // apb error
);

   import psm_pkg::*;

   // datapath signals
   psm_operand_t second_selected;   // second operand after the source mux
   psm_operand_t first_applied;     // first operand after its stage
   psm_operand_t second_applied;    // second operand after its stage
   psm_product_t raw_product;       // multiplier array output
   psm_product_t product_stage;     // product after its stage

   // register file state
   logic         ram_wide;          // neighbouring ram in 512 x 36 mode
   logic         next_ram_wide;
   logic         pready;            // access phase answer
   logic         next_pready;
   psm_data_t    prdata;            // captured read data
   psm_data_t    next_prdata;
   logic         pslverr;           // unmapped address answer
   logic         next_pslverr;

   // bus helpers
   psm_reg_t     sel_reg;           // register that paddr_in names
   logic         access_done;       // write or read completes this edge

   // map an address onto a register; shared by the write and read paths
   function automatic psm_reg_t psm_decode(input psm_addr_t addr);
      psm_reg_t r;
      r = PSM_REG_NONE;
      if (addr == `PSM_CTRL_OFS)
         r = PSM_REG_CTRL;
      else if (addr == `PSM_STATUS_OFS)
         r = PSM_REG_STATUS;
      else if (addr == `PSM_PROD_LO_OFS)
         r = PSM_REG_PROD_LO;
      else if (addr == `PSM_PROD_HI_OFS)
         r = PSM_REG_PROD_HI;
      else if (addr == `PSM_CHAIN_OFS)
         r = PSM_REG_CHAIN;
      return r;
   endfunction

   // second operand source is fixed at build time; no run-time select
   // exists, so a chain can never be re-steered while data is in flight
   always_comb
   begin
      if (SOURCE_SEL == PSM_SRC_CHAINED)
      begin
         second_selected = chain_operand_in;
      end
      else
      begin
         second_selected = second_operand_in;
      end
   end

   // first operand stage; a wire when the register is left out
   psm_stage
   #(
      .W       (`PSM_OPERAND_W),
      .PRESENT (FIRST_REG_PRESENT),
      .INV_CLK (INV_CLK),
      .INV_CE  (INV_FIRST_ENABLE),
      .INV_CLR (INV_FIRST_CLEAR)
   )
   u_first_stage
   (
      .clk_in        (ref_clk_in),
      .rst_in        (rst_in),
      .d_in          (first_operand_in),
      .enable_in     (first_operand_enable_in),
      .sync_clear_in (first_operand_sync_clear_in),
      .q_out         (first_applied)
   );

   // second operand stage; its output is also the chain output
   psm_stage
   #(
      .W       (`PSM_OPERAND_W),
      .PRESENT (SECOND_REG_PRESENT),
      .INV_CLK (INV_CLK),
      .INV_CE  (INV_SECOND_ENABLE),
      .INV_CLR (INV_SECOND_CLEAR)
   )
   u_second_stage
   (
      .clk_in        (ref_clk_in),
      .rst_in        (rst_in),
      .d_in          (second_selected),
      .enable_in     (second_operand_enable_in),
      .sync_clear_in (second_operand_sync_clear_in),
      .q_out         (second_applied)
   );

   // the array itself; with either operand unregistered this follows
   // that pin at once, so product timing mixes edge and pin changes.
   // in ram wide mode the array shares its upper operand routing with
   // the ram data inputs and is unusable, so it yields zero instead.
   always_comb
   begin
      if (ram_wide)
      begin
         raw_product = `PSM_PRODUCT_RESET;
      end
      else
      begin
         // widen both operands first so the signed product keeps all 36 bits
         raw_product = psm_product_t'(first_applied)
                     * psm_product_t'(second_applied);
      end
   end

   // product stage; a wire when the register is left out
   psm_stage
   #(
      .W       (`PSM_PRODUCT_W),
      .PRESENT (PRODUCT_REG_PRESENT),
      .INV_CLK (INV_CLK),
      .INV_CE  (INV_PRODUCT_ENABLE),
      .INV_CLR (INV_PRODUCT_CLEAR)
   )
   u_product_stage
   (
      .clk_in        (ref_clk_in),
      .rst_in        (rst_in),
      .d_in          (raw_product),
      .enable_in     (product_enable_in),
      .sync_clear_in (product_sync_clear_in),
      .q_out         (product_stage)
   );

   // outputs: the product and chain paths must stay combinational when
   // their registers are absent, so they cannot all come from flops here
   assign product_out       = product_stage;
   assign chain_operand_out = second_applied;

   // bus decode; one wait state, answer on the second access cycle
   assign sel_reg     = psm_decode(paddr_in);
   assign access_done = psel_in & penable_in & pready;

   // next values of the apb answer and the control register
   always_comb
   begin
      next_ram_wide = ram_wide;
      next_pready   = 1'b0;
      next_prdata   = prdata;
      next_pslverr  = 1'b0;
      // raise ready one cycle into the access phase, drop it after
      if (psel_in && penable_in && !pready)
      begin
         next_pready  = 1'b1;
         next_pslverr = (sel_reg == PSM_REG_NONE);
         // capture read data together with ready so it stands with it
         if (!pwrite_in)
         begin
            next_prdata = `PSM_RDATA_RESET;
            case (sel_reg)
               PSM_REG_CTRL:
               begin
                  next_prdata[`PSM_CTRL_RAM_WIDE_BIT] = ram_wide;
               end
               PSM_REG_STATUS:
               begin
                  next_prdata[`PSM_STAT_RAM_WIDE_BIT]   = ram_wide;
                  next_prdata[`PSM_STAT_FIRST_REG_BIT]  = FIRST_REG_PRESENT;
                  next_prdata[`PSM_STAT_SECOND_REG_BIT] = SECOND_REG_PRESENT;
                  next_prdata[`PSM_STAT_PROD_REG_BIT]   = PRODUCT_REG_PRESENT;
                  next_prdata[`PSM_STAT_CHAINED_BIT]    =
                     (SOURCE_SEL == PSM_SRC_CHAINED);
               end
               PSM_REG_PROD_LO:
               begin
                  next_prdata = product_stage[31:0];
               end
               PSM_REG_PROD_HI:
               begin
                  next_prdata[`PSM_PRODUCT_HI_W-1:0] =
                     product_stage[`PSM_PRODUCT_W-1:32];
               end
               PSM_REG_CHAIN:
               begin
                  next_prdata[`PSM_OPERAND_W-1:0] = second_applied;
               end
               default:
               begin
                  next_prdata = `PSM_RDATA_RESET;  // unmapped reads zero
               end
            endcase
         end
      end
      // writes take effect only at the completing edge
      if (access_done && pwrite_in && (sel_reg == PSM_REG_CTRL))
      begin
         next_ram_wide = pwdata_in[`PSM_CTRL_RAM_WIDE_BIT];
      end
   end

   // register the bus answer and control bit
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ram_wide <= `PSM_CTRL_RESET;
         pready   <= 1'b0;
         prdata   <= `PSM_RDATA_RESET;
         pslverr  <= 1'b0;
      end
      else
      begin
         ram_wide <= next_ram_wide;
         pready   <= next_pready;
         prdata   <= next_prdata;
         pslverr  <= next_pslverr;
      end
   end

   // bus outputs straight from their flops
   assign pready_out  = pready;
   assign prdata_out  = prdata;
   assign pslverr_out = pslverr;

endmodule

`default_nettype wire

// [src/psm_pkg.sv]
// types shared by the multiplier modules
// assumes psm_consts.svh sits on the include path
`include "psm_consts.svh"

package psm_pkg;

   // two's complement operand and product
   typedef logic signed [`PSM_OPERAND_W-1:0] psm_operand_t;
   typedef logic signed [`PSM_PRODUCT_W-1:0] psm_product_t;

   // apb address and data
   typedef logic [`PSM_APB_AW-1:0] psm_addr_t;
   typedef logic [31:0]            psm_data_t;

   // where the second operand comes from
   typedef enum logic {
      PSM_SRC_DIRECT,
      PSM_SRC_CHAINED
   } psm_src_t;

   // register selected by an apb address
   typedef enum logic [2:0] {
      PSM_REG_CTRL,
      PSM_REG_STATUS,
      PSM_REG_PROD_LO,
      PSM_REG_PROD_HI,
      PSM_REG_CHAIN,
      PSM_REG_NONE
   } psm_reg_t;

endpackage

// [src/psm_stage.sv]
// one optional pipeline register with clock enable and synchronous clear
// assumes a single clock; when absent the stage is a plain wire
`timescale 1ns/1ns
`default_nettype none

module psm_stage
#(
   parameter int W       = 18,
   parameter bit PRESENT = 1'b1,
   parameter bit INV_CLK = 1'b0,
   parameter bit INV_CE  = 1'b0,
   parameter bit INV_CLR = 1'b0
)
(
   input  wire logic         clk_in,        // shared clock
   input  wire logic         rst_in,        // asynchronous reset, active high
   input  wire logic [W-1:0] d_in,          // value to capture
   input  wire logic         enable_in,     // clock enable, raw pin polarity
   input  wire logic         sync_clear_in, // synchronous clear, raw pin polarity
   output logic      [W-1:0] q_out          // registered or passed value
);

   logic         enable;       // enable after the polarity option
   logic         sync_clear;   // clear after the polarity option
   logic [W-1:0] held;         // register contents
   logic [W-1:0] next_held;    // value for the next edge

   // enable and clear polarity options are folded in once, here
   assign enable     = enable_in ^ INV_CE;
   assign sync_clear = sync_clear_in ^ INV_CLR;

   // clear wins over enable; otherwise load only while enabled
   always_comb
   begin
      next_held = held;
      if (sync_clear)
      begin
         next_held = '0;
      end
      else if (enable)
      begin
         next_held = d_in;
      end
   end

   generate
      if (!PRESENT)
      begin : g_wire
         // no register: downstream sees the input at once
         assign held  = '0;
         assign q_out = d_in;
      end
      else if (INV_CLK)
      begin : g_fall
         // inverted clock option: capture on the falling edge
         always_ff @(negedge clk_in or posedge rst_in)
         begin
            if (rst_in)
               held <= '0;
            else
               held <= next_held;
         end
         assign q_out = held;
      end
      else
      begin : g_rise
         // normal polarity: capture on the rising edge
         always_ff @(posedge clk_in or posedge rst_in)
         begin
            if (rst_in)
               held <= '0;
            else
               held <= next_held;
         end
         assign q_out = held;
      end
   endgenerate

endmodule

`default_nettype wire

// [verif/pipelined_signed_multiplier_bench.sv]
// bench: fully registered direct multiplier beside an unregistered chained one
// assumes a 50 MHz clock and the neighbour model on the chain input
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("BAD %s exp %h got %h", n, e, g); end end
module pipelined_signed_multiplier_bench;
   import psm_pkg::*;
   typedef struct {psm_product_t p, cp, xp; psm_operand_t b, cb;} psm_exp_t;
   logic         ref_clk_in = 0, rst_in = 1, nb_en, done, rw, hold = 0;
   logic         psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
   logic         first_operand_enable_in, first_operand_sync_clear_in;
   logic         second_operand_enable_in, second_operand_sync_clear_in;
   logic         product_enable_in, product_sync_clear_in;
   psm_operand_t first_operand_in, second_operand_in, chain_operand_in, nb_b;
   psm_operand_t chain_operand_out, c_chain, ma, mb, nbr, xa;
   psm_product_t product_out, c_prod, mp, x_prod;
   psm_addr_t    paddr_in;
   psm_data_t    pwdata_in, prdata_out;
   psm_exp_t     q_dp[$], m_e;
   logic [32:0]  q_rd[$], r_e; // {error, read data}
   logic [31:0]  lf = 32'h3e86;
   int           n_fail = 0, n_compared = 0;
   psm_mult u_dut (.*);
   psm_mult #(.FIRST_REG_PRESENT(1'b0), .SECOND_REG_PRESENT(1'b0),
      .PRODUCT_REG_PRESENT(1'b0), .SOURCE_SEL(PSM_SRC_CHAINED)) u_comb (.*,
      .product_out(c_prod), .chain_operand_out(c_chain), .pready_out(), .prdata_out(),
      .pslverr_out());
   // only the first operand registered, with inverted controls: mixed timing
   psm_mult #(.SECOND_REG_PRESENT(1'b0), .PRODUCT_REG_PRESENT(1'b0),
      .INV_FIRST_ENABLE(1'b1), .INV_FIRST_CLEAR(1'b1)) u_mix (.*,
      .product_out(x_prod), .chain_operand_out(), .pready_out(), .prdata_out(),
      .pslverr_out());
   psm_neighbour u_nb (.ref_clk_in, .rst_in, .nb_operand_in(nb_b), .nb_enable_in(nb_en),
      .nb_chain_out(chain_operand_in));
   always #10 ref_clk_in = ~ref_clk_in;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic psm_product_t mul(input psm_operand_t a, input psm_operand_t b);
      return psm_product_t'(a) * psm_product_t'(b);
   endfunction
   // one clock: advance the reference stages, then drive fresh inputs
   task automatic step(input bit bnd, input bit r);
      psm_exp_t     e;
      psm_operand_t na, nb;
      logic [5:0]   c;
      @(posedge ref_clk_in);
      done = psel_in && penable_in && pready_out;
      if (product_sync_clear_in) mp = '0;
      else if (product_enable_in) mp = rw ? '0 : mul(ma, mb);
      if (first_operand_sync_clear_in) ma = '0;
      else if (first_operand_enable_in) ma = first_operand_in;
      if (!first_operand_sync_clear_in) xa = '0;
      else if (!first_operand_enable_in) xa = first_operand_in;
      if (second_operand_sync_clear_in) mb = '0;
      else if (second_operand_enable_in) mb = second_operand_in;
      if (nb_en) nbr = nb_b;
      if (done && pwrite_in && paddr_in == 12'h000) rw = pwdata_in[0];
      if (r || rst_in) {ma, mb, nbr, mp, rw, xa} = '0;
      lf = lfsr(lf);
      na = bnd ? 18'h20000 : lf[17:0];
      lf = lfsr(lf);
      nb = bnd ? 18'h20000 : lf[17:0];
      lf = lfsr(lf);
      c = bnd ? 6'h2a : hold ? 6'h00 : {|lf[1:0], lf[4:2] == 3'h0, |lf[6:5], lf[9:7] == 3'h0,
                         |lf[11:10], lf[14:12] == 3'h0};
      first_operand_in <= na;
      second_operand_in <= nb;
      nb_b <= lf[31:14];
      nb_en <= lf[13];
      {first_operand_enable_in, first_operand_sync_clear_in, second_operand_enable_in,
       second_operand_sync_clear_in, product_enable_in, product_sync_clear_in} <= c;
      rst_in <= r;
      e.p = mp;
      e.b = mb;
      e.cb = nbr;
      e.cp = rw ? '0 : mul(na, nbr);
      e.xp = rw ? '0 : mul(xa, nb);
      q_dp.push_back(e);
   endtask
   // one bus transfer; the expected answer is noted before it starts
   task automatic apb(input bit w, input psm_addr_t a, input psm_data_t d, input logic [32:0] x);
      step(0, 0);
      q_rd.push_back(x);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      step(0, 0);
      penable_in <= 1'b1;
      // wait for ready however long it takes; only the watchdog ends a hang
      do
      begin
         step(0, 0);
      end
      while (!done);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   // datapath outputs are settled by the falling edge
   always @(negedge ref_clk_in)
      if (q_dp.size() > 0)
      begin
         m_e = q_dp.pop_front();
         `CHK("product", m_e.p, product_out)
         `CHK("chain out", m_e.b, chain_operand_out)
         `CHK("direct product", m_e.cp, c_prod)
         `CHK("direct chain out", m_e.cb, c_chain)
         `CHK("one-reg product", m_e.xp, x_prod)
      end
   // bus answer taken at the edge where ready is seen
   always @(posedge ref_clk_in)
      if (psel_in && penable_in && pready_out)
      begin
         r_e = q_rd.pop_front();
         `CHK("pslverr", r_e[32], pslverr_out)
         if (!pwrite_in) `CHK("prdata", r_e[31:0], prdata_out)
      end
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, nb_en, nb_b} = '0;
      {first_operand_in, second_operand_in, first_operand_enable_in} = '0;
      {first_operand_sync_clear_in, second_operand_enable_in} = '0;
      {second_operand_sync_clear_in, product_enable_in, product_sync_clear_in} = '0;
      repeat (2) step(0, 1);
      repeat (4) step(1, 0); // most negative operands, largest product
      repeat (300) step(0, 0);
      apb(0, 12'h004, 0, 33'he); // three stages present, direct source
      apb(1, 12'h000, 1, 33'h0);
      apb(0, 12'h000, 0, 33'h1);
      apb(1, 12'h004, 0, 33'h0); // read-only place, ignored
      apb(0, 12'h004, 0, 33'hf);
      repeat (20) step(0, 0); // wide ram: products forced to zero
      apb(0, 12'h014, 0, 33'h100000000); // unmapped place
      apb(1, 12'h000, 0, 33'h0);
      hold = 1;
      step(0, 0); // freeze the datapath so product and chain reads are known
      apb(0, 12'h008, 0, {1'b0, mp[31:0]});
      apb(0, 12'h00c, 0, {29'h0, mp[35:32]});
      apb(0, 12'h010, 0, {15'h0, mb});
      hold = 0;
      repeat (50) step(0, 0);
      step(0, 1); // reset again in mid-run
      repeat (50) step(0, 0);
      give_verdict;
   end
   initial
   begin
      #200000;
      n_fail++;
      give_verdict;
   end
endmodule
`default_nettype wire

// [verif/psm_mult_monitor.sv]
// checker on the multiplier ports: operand and product stage timing
// assumes the datapath stages run on the rising clock edge
`timescale 1ns/1ns
`default_nettype none
module psm_mult_monitor
#(
   parameter bit                FIRST_REG_PRESENT   = 1'b1,
   parameter bit                SECOND_REG_PRESENT  = 1'b1,
   parameter bit                PRODUCT_REG_PRESENT = 1'b1,
   parameter psm_pkg::psm_src_t SOURCE_SEL          = psm_pkg::PSM_SRC_DIRECT
)
(
   input wire logic                  ref_clk_in,
   input wire logic                  rst_in,
   input wire psm_pkg::psm_operand_t first_operand_in,
   input wire psm_pkg::psm_operand_t second_operand_in,
   input wire psm_pkg::psm_operand_t chain_operand_in,
   input wire logic                  second_operand_enable_in,
   input wire logic                  second_operand_sync_clear_in,
   input wire logic                  first_operand_enable_in,
   input wire logic                  first_operand_sync_clear_in,
   input wire logic                  product_enable_in,
   input wire logic                  product_sync_clear_in,
   input wire psm_pkg::psm_product_t product_out,
   input wire psm_pkg::psm_operand_t chain_operand_out,
   input wire logic                  psel_in,
   input wire logic                  penable_in,
   input wire logic                  pwrite_in,
   input wire psm_pkg::psm_addr_t    paddr_in,
   input wire psm_pkg::psm_data_t    pwdata_in,
   input wire logic                  pready_out
);
   import psm_pkg::*;
   logic         ram_wide_m; // mirror of the wide-ram bit, from bus writes
   psm_operand_t bsel;       // second operand that the source setting picks
   assign bsel = (SOURCE_SEL == PSM_SRC_CHAINED) ? chain_operand_in : second_operand_in;
   // the bit lands at the completing edge of a control write
   always_ff @(posedge ref_clk_in or posedge rst_in)
      if (rst_in)
         ram_wide_m <= 1'b0;
      else if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h000)
         ram_wide_m <= pwdata_in[0];
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   property p_b_load;
      SECOND_REG_PRESENT && !rst_in && second_operand_enable_in && !second_operand_sync_clear_in
         |=> chain_operand_out == $past(bsel);
   endproperty
   a_b_load: assert property (p_b_load) else $error("second stage missed a load");
   property p_b_clear;
      SECOND_REG_PRESENT && second_operand_sync_clear_in |=> chain_operand_out == '0;
   endproperty
   a_b_clear: assert property (p_b_clear) else $error("second stage not cleared");
   property p_b_hold;
      SECOND_REG_PRESENT && !second_operand_enable_in && !second_operand_sync_clear_in
         |=> $stable(chain_operand_out);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("chain out moved while held");
   property p_b_comb;
      !SECOND_REG_PRESENT |-> chain_operand_out == bsel;
   endproperty
   a_b_comb: assert property (p_b_comb) else $error("chain out not the picked source");
   property p_p_clear;
      PRODUCT_REG_PRESENT && product_sync_clear_in |=> product_out == '0;
   endproperty
   a_p_clear: assert property (p_p_clear) else $error("product not cleared");
   property p_p_hold;
      PRODUCT_REG_PRESENT && !product_enable_in && !product_sync_clear_in
         |=> $stable(product_out);
   endproperty
   a_p_hold: assert property (p_p_hold) else $error("product moved while held");
   property p_p_load;
      FIRST_REG_PRESENT && SECOND_REG_PRESENT && PRODUCT_REG_PRESENT && !rst_in
         && first_operand_enable_in && !first_operand_sync_clear_in
         ##1 product_enable_in && !product_sync_clear_in && !ram_wide_m
         |=> product_out == psm_product_t'($past(first_operand_in, 2))
                            * psm_product_t'($past(chain_operand_out));
   endproperty
   a_p_load: assert property (p_p_load) else $error("product stage wrong value");
   property p_comb;
      !FIRST_REG_PRESENT && !SECOND_REG_PRESENT && !PRODUCT_REG_PRESENT && !ram_wide_m
         |-> product_out == psm_product_t'(first_operand_in) * psm_product_t'(bsel);
   endproperty
   a_comb: assert property (p_comb) else $error("direct product wrong");
endmodule
bind psm_mult psm_mult_monitor #(
   .FIRST_REG_PRESENT(FIRST_REG_PRESENT), .SECOND_REG_PRESENT(SECOND_REG_PRESENT),
   .PRODUCT_REG_PRESENT(PRODUCT_REG_PRESENT), .SOURCE_SEL(SOURCE_SEL)) u_mon (.*);
`default_nettype wire

// [verif/psm_neighbour.sv]
// neighbouring multiplier: its registered second operand feeds our chain input
// assumes the bench drives its operand and enable just after the rising edge
`timescale 1ns/1ns
`default_nettype none
module psm_neighbour
(
   input  wire logic                  ref_clk_in,
   input  wire logic                  rst_in,
   input  wire psm_pkg::psm_operand_t nb_operand_in,
   input  wire logic                  nb_enable_in,
   output psm_pkg::psm_operand_t      nb_chain_out
);
   import psm_pkg::*;
   psm_operand_t nb_reg;      // neighbour's own second-operand stage
   psm_operand_t next_nb_reg; // its next value
   // loads only when enabled, so the chain value can sit still for a while
   always_comb next_nb_reg = nb_enable_in ? nb_operand_in : nb_reg;
   always_ff @(posedge ref_clk_in or posedge rst_in)
      if (rst_in)
         nb_reg <= '0;
      else
         nb_reg <= next_nb_reg;
   assign nb_chain_out = nb_reg;
endmodule
`default_nettype wire
